// ### input_sync_parameters.sv
// Input synchronisation parameter bank with Avalon-MM slave
`include "sync_params.svh"
module input_sync_parameters (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic avs_response_err_out,
  input wire logic sync0_pin_in,
  input wire logic sync1_pin_in,
  input wire logic sample_pin_in,
  input wire logic avail_pin_in,
  input wire logic sm_event_pin_in,
  input wire logic cycle_start_pin_in,
  input wire logic cycle_done_pin_in,
  input wire logic op_state_pin_in,
  output logic [15:0] sync_mode_out,
  output logic measuring_out,
  output logic sync_error_out
);
  import sync_pkg::*;

  sync_event_if ev_bus ();

  timing_s timing;
  logic [15:0] missed;
  logic [15:0] overrun;
  logic [15:0] short_cnt;
  logic err_flag;

  bus_state_e state;
  bus_state_e next_state;
  logic [15:0] mode;
  logic [31:0] cycle_ns;
  logic [15:0] command;
  logic clear_pulse;
  logic [31:0] readdata;
  logic resp_err;
  logic [15:0] next_mode;
  logic [31:0] next_cycle_ns;
  logic [15:0] next_command;
  logic next_clear_pulse;
  logic [31:0] next_readdata;
  logic next_resp_err;
  logic [5:0] index;
  logic index_ok;
  logic [31:0] wr_mode;
  logic [31:0] wr_cmd;

  sync_event_in u_event_in (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .pins_in({op_state_pin_in, cycle_done_pin_in, cycle_start_pin_in, sm_event_pin_in,
              avail_pin_in, sample_pin_in, sync1_pin_in, sync0_pin_in}),
    .ev(ev_bus.source)
  );

  sync_measure u_measure (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .mode_in(mode),
    .measuring_in(command == `CMD_START),
    .clear_in(clear_pulse),
    .ev(ev_bus.sink),
    .timing_out(timing),
    .missed_out(missed),
    .overrun_out(overrun),
    .short_out(short_cnt),
    .sync_error_out(err_flag)
  );

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    merge = r;
  endfunction : merge

  function automatic logic mode_legal(input logic [15:0] m);
    mode_legal = (m == `MODE_FREE_RUN) || (m == `MODE_INPUT_EVENT) || (m == `MODE_SYNC0) ||
                 (m == `MODE_SYNC1) || (m == `MODE_OUTPUT_EVENT);
  endfunction : mode_legal

  assign index = avs_address_in[7:2];
  assign wr_mode = merge({16'h0000, mode}, avs_writedata_in, avs_byteenable_in);
  assign wr_cmd = merge({16'h0000, command}, avs_writedata_in, avs_byteenable_in);
  assign index_ok = (index <= {2'b00, `IDX_SHORT_SHIFT}) && (index != 6'h0a) || (index == `IDX_SYNC_ERROR);

  //==============================================================
  // Register bus and writable entries
  always_comb begin
    next_state = state;
    next_mode = mode;
    next_cycle_ns = cycle_ns;
    next_command = command;
    next_clear_pulse = 1'b0;
    next_readdata = readdata;
    next_resp_err = resp_err;
    unique case (state)
      bus_idle: begin
        if (avs_read_in || avs_write_in) begin
          next_state = bus_answer;
          next_resp_err = !index_ok;
          next_readdata = 32'h00000000;
          if (avs_read_in) begin
            unique case (index)
              {2'b00, `IDX_ENTRY_COUNT}: next_readdata = {24'h000000, `RST_ENTRY_COUNT};
              {2'b00, `IDX_MODE}: next_readdata = {16'h0000, mode};
              {2'b00, `IDX_CYCLE}: next_readdata = cycle_ns;
              {2'b00, `IDX_SHIFT}: next_readdata = timing.shift_ns;
              {2'b00, `IDX_SUPPORTED}: next_readdata = {16'h0000, `RST_SUPPORTED};
              {2'b00, `IDX_MIN_CYCLE}: next_readdata = `RST_MIN_CYCLE;
              {2'b00, `IDX_CALC_COPY}: next_readdata = timing.calc_copy_ns;
              {2'b00, `IDX_MIN_DELAY}: next_readdata = 32'h00000000;
              {2'b00, `IDX_COMMAND}: next_readdata = {16'h0000, command};
              {2'b00, `IDX_MAX_DELAY}: next_readdata = timing.max_delay_ns;
              {2'b00, `IDX_MISSED}: next_readdata = {16'h0000, missed};
              {2'b00, `IDX_OVERRUN}: next_readdata = {16'h0000, overrun};
              {2'b00, `IDX_SHORT_SHIFT}: next_readdata = {16'h0000, short_cnt};
              `IDX_SYNC_ERROR: next_readdata = {31'h00000000, err_flag};
              default: next_readdata = 32'h00000000;
            endcase
          end
        end
      end
      bus_answer: begin
        next_state = bus_idle;
        // Write lands at the edge that ends the request; read-only entries keep their value
        if (avs_write_in) begin
          unique case (index)
            {2'b00, `IDX_MODE}: begin
              if (mode_legal(wr_mode[15:0])) begin
                next_mode = wr_mode[15:0];
              end
            end
            {2'b00, `IDX_CYCLE}: next_cycle_ns = merge(cycle_ns, avs_writedata_in, avs_byteenable_in);
            {2'b00, `IDX_COMMAND}: begin
              next_command = wr_cmd[15:0];
              if (wr_cmd[15:0] == `CMD_START && command != `CMD_START) begin
                next_clear_pulse = 1'b1;
              end
            end
            default: next_command = command;
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      state <= bus_idle;
      mode <= `RST_MODE;
      cycle_ns <= `RST_CYCLE;
      command <= `RST_COMMAND;
      clear_pulse <= 1'b0;
      readdata <= 32'h00000000;
      resp_err <= 1'b0;
    end else begin
      state <= next_state;
      mode <= next_mode;
      cycle_ns <= next_cycle_ns;
      command <= next_command;
      clear_pulse <= next_clear_pulse;
      readdata <= next_readdata;
      resp_err <= next_resp_err;
    end
  end

  //==============================================================
  // Output registers
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      avs_readdata_out <= 32'h00000000;
      avs_waitrequest_out <= 1'b1;
      avs_response_err_out <= 1'b0;
      sync_mode_out <= `RST_MODE;
      measuring_out <= 1'b0;
      sync_error_out <= 1'b0;
    end else begin
      avs_readdata_out <= next_readdata;
      avs_waitrequest_out <= !(next_state == bus_answer);
      avs_response_err_out <= next_resp_err;
      sync_mode_out <= next_mode;
      measuring_out <= (next_command == `CMD_START);
      sync_error_out <= err_flag;
    end
  end
endmodule : input_sync_parameters

// ### sync_params.svh
// Register map, reset values and timing constants of the input sync parameter bank
//==============================================================
// Function
// - Sync mode codes: 0 free run, 1 input event, 2 SYNC0, 3 SYNC1, 34 output event.
// - Supported word: bit0 free run, bit1 event lock, bits 2-3 = 01 clock mode.
// - Supported bits 4-5: 01 local-event shift, 10 shift to SYNC1 without outputs.
// - Supported bit 14 flags dynamic times measured after a command write.
// - Report SYNC0-to-sampling delay in ns, only in clock-sync modes.
// - Report sampling-to-available time in ns, only in clock-sync modes.
// - Report maximum SYNC1-to-sampling delay in ns, only in clock-sync modes.
// - Command 1 starts cycle measurement, 0 stops; maxima update timing entries.
// - Count missed sync-manager events in operational clock-sync mode, 16 bits.
// - Count late-finishing or early-starting cycles in operational state.
// - Set sync error flag when the last clock-sync cycle failed or was late.
`ifndef SYNC_PARAMS_SVH
`define SYNC_PARAMS_SVH

//==============================================================
// Entry indices; byte address is four times the index
`define IDX_ENTRY_COUNT 4'h0
`define IDX_MODE 4'h1
`define IDX_CYCLE 4'h2
`define IDX_SHIFT 4'h3
`define IDX_SUPPORTED 4'h4
`define IDX_MIN_CYCLE 4'h5
`define IDX_CALC_COPY 4'h6
`define IDX_MIN_DELAY 4'h7
`define IDX_COMMAND 4'h8
`define IDX_MAX_DELAY 4'h9
`define IDX_MISSED 4'hb
`define IDX_OVERRUN 4'hc
`define IDX_SHORT_SHIFT 4'hd
`define IDX_SYNC_ERROR 6'h20

//==============================================================
// Reset values
`define RST_ENTRY_COUNT 8'h20
`define RST_MODE 16'h0022
`define RST_CYCLE 32'h000f4240
`define RST_SUPPORTED 16'hc007
`define RST_MIN_CYCLE 32'h000249f0
`define RST_COMMAND 16'h0000

//==============================================================
// Mode codes and command values
`define MODE_FREE_RUN 16'h0000
`define MODE_INPUT_EVENT 16'h0001
`define MODE_SYNC0 16'h0002
`define MODE_SYNC1 16'h0003
`define MODE_OUTPUT_EVENT 16'h0022
`define CMD_START 16'h0001
`define CMD_STOP 16'h0000

//==============================================================
// Timing: one clock period in ns
`define CLK_PERIOD_NS 32'h00000004

`endif

// ### sync_pkg.sv
// Types shared by the input sync parameter bank
package sync_pkg;

  typedef enum logic [1:0] {
    bus_idle,
    bus_answer
  } bus_state_e;

  typedef struct packed {
    logic [31:0] shift_ns;
    logic [31:0] calc_copy_ns;
    logic [31:0] max_delay_ns;
  } timing_s;

endpackage : sync_pkg

// ### sync_event_if.sv
// Synchronised event strobes from the pin stage to the measurement stage
interface sync_event_if;
  logic sync0;
  logic sync1;
  logic sample;
  logic avail;
  logic sm_event;
  logic cycle_start;
  logic cycle_done;
  logic op_state;

  modport source (
    output sync0, sync1, sample, avail, sm_event, cycle_start, cycle_done, op_state
  );
  modport sink (
    input sync0, sync1, sample, avail, sm_event, cycle_start, cycle_done, op_state
  );
endinterface : sync_event_if

// ### sync_event_in.sv
// Two-stage synchronisers and rising-edge detection of the event pins; op_state is passed on as a level
module sync_event_in (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic [7:0] pins_in,
  sync_event_if.source ev
);
  import sync_pkg::*;

  logic [7:0] meta;
  logic [7:0] stable;
  logic [7:0] last;
  logic [7:0] next_meta;
  logic [7:0] next_stable;
  logic [7:0] next_last;

  always_comb begin
    next_meta = pins_in;
    next_stable = meta;
    next_last = stable;
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      meta <= 8'h00;
      stable <= 8'h00;
      last <= 8'h00;
    end else begin
      meta <= next_meta;
      stable <= next_stable;
      last <= next_last;
    end
  end

  assign ev.sync0 = stable[0] & ~last[0];
  assign ev.sync1 = stable[1] & ~last[1];
  assign ev.sample = stable[2] & ~last[2];
  assign ev.avail = stable[3] & ~last[3];
  assign ev.sm_event = stable[4] & ~last[4];
  assign ev.cycle_start = stable[5] & ~last[5];
  assign ev.cycle_done = stable[6] & ~last[6];
  assign ev.op_state = stable[7];
endmodule : sync_event_in

// ### sync_measure.sv
// Cycle timing measurement, missed-event and overrun counting
`include "sync_params.svh"
module sync_measure (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic [15:0] mode_in,
  input wire logic measuring_in,
  input wire logic clear_in,
  sync_event_if.sink ev,
  output sync_pkg::timing_s timing_out,
  output logic [15:0] missed_out,
  output logic [15:0] overrun_out,
  output logic [15:0] short_out,
  output logic sync_error_out
);
  import sync_pkg::*;

  function automatic logic [31:0] sat_inc(input logic [31:0] v);
    sat_inc = (v > 32'hffffffff - `CLK_PERIOD_NS) ? 32'hffffffff : v + `CLK_PERIOD_NS;
  endfunction : sat_inc

  function automatic logic [15:0] inc16(input logic [15:0] v);
    inc16 = (v == 16'hffff) ? v : v + 16'h0001;
  endfunction : inc16

  logic dc_mode;
  logic [31:0] t_sync0;
  logic [31:0] t_sync1;
  logic [31:0] t_sample;
  logic run0;
  logic run1;
  logic runs;
  logic in_cycle;
  logic sm_seen;
  logic [31:0] next_t_sync0;
  logic [31:0] next_t_sync1;
  logic [31:0] next_t_sample;
  logic next_run0;
  logic next_run1;
  logic next_runs;
  logic next_in_cycle;
  logic next_sm_seen;
  timing_s next_timing;
  logic [15:0] next_missed;
  logic [15:0] next_overrun;
  logic [15:0] next_short;
  logic next_sync_error;

  assign dc_mode = (mode_in == `MODE_SYNC0) || (mode_in == `MODE_SYNC1);

  //==============================================================
  // Next-state computation
  always_comb begin
    next_t_sync0 = run0 ? sat_inc(t_sync0) : 32'h00000000;
    next_t_sync1 = run1 ? sat_inc(t_sync1) : 32'h00000000;
    next_t_sample = runs ? sat_inc(t_sample) : 32'h00000000;
    next_run0 = run0;
    next_run1 = run1;
    next_runs = runs;
    next_in_cycle = in_cycle;
    next_sm_seen = sm_seen;
    next_timing = timing_out;
    next_missed = missed_out;
    next_overrun = overrun_out;
    next_short = short_out;
    next_sync_error = sync_error_out;
    if (clear_in) begin
      next_timing = '0;
    end
    if (ev.sync0) begin
      next_run0 = 1'b1;
      next_t_sync0 = 32'h00000000;
    end
    if (ev.sync1) begin
      next_run1 = 1'b1;
      next_t_sync1 = 32'h00000000;
      if (run0 && dc_mode && measuring_in && t_sync0 == 32'h00000000) begin
        next_short = inc16(short_out);
      end
    end
    if (ev.sample) begin
      next_run0 = 1'b0;
      next_run1 = 1'b0;
      next_runs = 1'b1;
      next_t_sample = 32'h00000000;
      if (dc_mode && measuring_in) begin
        // Elapsed time counts the capturing edge too
        if (run0 && sat_inc(t_sync0) > next_timing.shift_ns) begin
          next_timing.shift_ns = sat_inc(t_sync0);
        end
        if (run1 && sat_inc(t_sync1) > next_timing.max_delay_ns) begin
          next_timing.max_delay_ns = sat_inc(t_sync1);
        end
      end
    end
    if (ev.avail) begin
      next_runs = 1'b0;
      if (dc_mode && measuring_in && runs && sat_inc(t_sample) > next_timing.calc_copy_ns) begin
        next_timing.calc_copy_ns = sat_inc(t_sample);
      end
    end
    if (ev.sm_event) begin
      next_sm_seen = 1'b1;
    end
    if (ev.sync0 && dc_mode) begin
      next_sm_seen = ev.sm_event;
      if (ev.op_state && !sm_seen) begin
        next_missed = inc16(missed_out);
      end
      next_sync_error = sm_seen ? runs : 1'b1;
    end
    if (ev.cycle_start) begin
      next_in_cycle = 1'b1;
      if (in_cycle && ev.op_state) begin
        next_overrun = inc16(overrun_out);
      end
    end
    if (ev.cycle_done && !ev.cycle_start) begin
      next_in_cycle = 1'b0;
    end
    if (!dc_mode) begin
      next_sync_error = 1'b0;
    end
  end

  //==============================================================
  // State registers
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      t_sync0 <= 32'h00000000;
      t_sync1 <= 32'h00000000;
      t_sample <= 32'h00000000;
      run0 <= 1'b0;
      run1 <= 1'b0;
      runs <= 1'b0;
      in_cycle <= 1'b0;
      sm_seen <= 1'b1;
      timing_out <= '0;
      missed_out <= 16'h0000;
      overrun_out <= 16'h0000;
      short_out <= 16'h0000;
      sync_error_out <= 1'b0;
    end else begin
      t_sync0 <= next_t_sync0;
      t_sync1 <= next_t_sync1;
      t_sample <= next_t_sample;
      run0 <= next_run0;
      run1 <= next_run1;
      runs <= next_runs;
      in_cycle <= next_in_cycle;
      sm_seen <= next_sm_seen;
      timing_out <= next_timing;
      missed_out <= next_missed;
      overrun_out <= next_overrun;
      short_out <= next_short;
      sync_error_out <= next_sync_error;
    end
  end
endmodule : sync_measure

// ### input_sync_parameters_monitor.sv
// Checker of the register bus handshake and register side effects
module input_sync_parameters_monitor (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic avs_response_err_out,
  input wire logic [15:0] sync_mode_out,
  input wire logic measuring_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  logic [5:0] idx;
  logic [15:0] wd;
  assign idx = avs_address_in[7:2];
  assign wd = avs_writedata_in[15:0];
  function automatic logic mapped(input logic [5:0] i);
    return i <= 6'h09 || (i >= 6'h0b && i <= 6'h0d) || i == 6'h20;
  endfunction : mapped
  function automatic logic legal(input logic [15:0] m);
    return m <= 16'h0003 || m == 16'h0022;
  endfunction : legal
  //==============================================================
  // Handshake steps
  sequence take_any;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  sequence take_rd;
    avs_read_in && avs_waitrequest_out;
  endsequence
  sequence done_wr(i);
    avs_write_in && !avs_waitrequest_out && idx == i && avs_byteenable_in == 4'hf;
  endsequence
  sequence answer;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence
  //==============================================================
  // Properties
  a_answer_next: assert property (take_any |=> answer) else $error("answer not one cycle after request");
  a_wait_idle: assert property (!avs_read_in && !avs_write_in && avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("answer without request");
  a_err_map: assert property (take_any |=> avs_response_err_out == !mapped($past(idx)))
    else $error("error response wrong");
  a_unmapped_zero: assert property (take_rd |=> mapped($past(idx)) || avs_readdata_out == 32'h0)
    else $error("unmapped read data not zero");
  a_modes_word: assert property (take_rd ##0 idx == 6'h04 |=> avs_readdata_out == 32'h0000c007)
    else $error("supported modes word wrong");
  a_mode_write: assert property (done_wr(6'h01) ##0 legal(wd) |=> sync_mode_out == $past(wd))
    else $error("mode not taken");
  a_mode_illegal: assert property (done_wr(6'h01) ##0 !legal(wd) |=> $stable(sync_mode_out))
    else $error("illegal mode taken");
  a_cmd_measure: assert property (done_wr(6'h08) |=> measuring_out == ($past(wd) == 16'h0001))
    else $error("measuring flag wrong");
  a_mode_reset: assert property ($fell(reset_in) |-> sync_mode_out == 16'h0022 && !measuring_out)
    else $error("reset values wrong");
endmodule : input_sync_parameters_monitor

// ### sync_event_source.sv
// Event pin source standing in for the cyclic bus timing
module sync_event_source (
  input wire logic sys_clk_in,
  input wire logic run_in,
  input wire logic op_in,
  input wire logic miss_sm_in,
  input wire logic late_done_in,
  output logic [7:0] pins_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int ph = 0;
  function automatic logic pulse(input int p, input int at);
    return p >= at && p < at + 4;
  endfunction : pulse
  always @(posedge sys_clk_in) begin
    ph <= (run_in && ph < 39) ? ph + 1 : 0;
  end
  always_comb begin
    pins_out = {op_in, 7'h00};
    if (run_in) begin
      pins_out[0] = pulse(ph, 0);
      pins_out[1] = pulse(ph, 6);
      pins_out[2] = pulse(ph, 10);
      pins_out[3] = pulse(ph, 18);
      pins_out[4] = pulse(ph, 25) && !miss_sm_in;
      pins_out[5] = pulse(ph, 2);
      pins_out[6] = pulse(ph, late_done_in ? 44 : 30);
    end
  end
endmodule : sync_event_source

// ### test_input_sync_parameters.sv
// Self-checking bench of the input sync parameter bank
`define CHECK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module test_input_sync_parameters;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] avs_address_in = 8'h00;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [3:0] avs_byteenable_in = 4'hf;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic avs_response_err_out;
  logic [15:0] sync_mode_out;
  logic measuring_out;
  logic sync_error_out;
  logic run = 1'b0;
  logic op = 1'b0;
  logic miss = 1'b0;
  logic late = 1'b0;
  logic [7:0] pins;
  logic [31:0] rq;
  logic re;
  logic [31:0] d;
  logic [31:0] old;
  logic [3:0] b;
  int mismatches = 0;
  int samples_checked = 0;
  logic [7:0] ra [14] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h2c, 8'h30,
    8'h34, 8'h80};
  logic [31:0] rv [14] = '{32'h20, 32'h22, 32'hf4240, 32'h0, 32'hc007, 32'h249f0, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h0, 32'h0, 32'h0};
  logic [15:0] mc [5] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h22};
  always #2 sys_clk_in = ~sys_clk_in;
  input_sync_parameters u_input_sync_parameters (.sys_clk_in, .reset_in, .avs_address_in, .avs_read_in,
    .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
    .avs_response_err_out, .sync0_pin_in(pins[0]), .sync1_pin_in(pins[1]), .sample_pin_in(pins[2]),
    .avail_pin_in(pins[3]), .sm_event_pin_in(pins[4]), .cycle_start_pin_in(pins[5]),
    .cycle_done_pin_in(pins[6]), .op_state_pin_in(pins[7]), .sync_mode_out, .measuring_out, .sync_error_out);
  sync_event_source u_sync_event_source (.sys_clk_in, .run_in(run), .op_in(op), .miss_sm_in(miss),
    .late_done_in(late), .pins_out(pins));
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] m);
    for (int k = 0; k < 4; k++) if (m[k]) o[8*k+:8] = n[8*k+:8];
    return o;
  endfunction : merge
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v, input logic [3:0] m);
    int n;
    @(posedge sys_clk_in);
    avs_address_in <= a;
    avs_writedata_in <= v;
    avs_byteenable_in <= m;
    avs_write_in <= w;
    avs_read_in <= !w;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk_in);
      if (avs_waitrequest_out === 1'b0) break;
    end
    if (n == 50) begin
      mismatches++;
      summarize();
    end
    rq = avs_readdata_out;
    re = avs_response_err_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bus(1'b1, a, v, 4'hf);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0, 4'hf);
  endtask : rd
  initial begin
    void'($urandom(32'h3f7f));
    repeat (2) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    for (int i = 0; i < 14; i++) begin
      rd(ra[i]);
      `CHECK("reset", rv[i], rq)
      `CHECK("err", 1'b0, re)
    end
    $display("reset values done");
    for (int i = 0; i < 14; i++) begin
      if (i == 1 || i == 2 || i == 8) continue;
      wr(ra[i], $urandom());
      rd(ra[i]);
      `CHECK("read only", rv[i], rq)
    end
    for (int i = 0; i < 2; i++) begin
      rd(i ? 8'h84 : 8'h28);
      `CHECK("unmapped err", 1'b1, re)
      `CHECK("unmapped data", 32'h0, rq)
    end
    $display("read only done");
    for (int i = 0; i < 5; i++) begin
      wr(8'h04, {16'h0, mc[i]});
      rd(8'h04);
      `CHECK("mode", {16'h0, mc[i]}, rq)
      `CHECK("mode pin", mc[i], sync_mode_out)
    end
    wr(8'h04, 32'h4 + $urandom_range(0, 29));
    @(posedge sys_clk_in);
    `CHECK("illegal mode", 16'h0022, sync_mode_out)
    old = 32'hf4240;
    for (int i = 0; i < 3; i++) begin
      d = $urandom();
      b = 4'($urandom_range(1, 15));
      bus(1'b1, 8'h08, d, b);
      old = merge(old, d, b);
      rd(8'h08);
      `CHECK("cycle time", old, rq)
    end
    $display("modes done");
    wr(8'h04, 32'h2);
    run <= 1'b1;
    op <= 1'b1;
    wr(8'h20, 32'h1);
    @(posedge sys_clk_in);
    `CHECK("measuring", 1'b1, measuring_out)
    repeat (160) @(posedge sys_clk_in);
    wr(8'h20, 32'h0);
    @(posedge sys_clk_in);
    `CHECK("stopped", 1'b0, measuring_out)
    rd(8'h0c);
    `CHECK("shift", 32'd40, rq)
    rd(8'h18);
    `CHECK("copy", 32'd32, rq)
    rd(8'h24);
    `CHECK("max delay", 32'd16, rq)
    rd(8'h2c);
    `CHECK("no miss", 32'h0, rq)
    `CHECK("no error", 1'b0, sync_error_out)
    $display("measurement done");
    miss <= 1'b1;
    repeat (120) @(posedge sys_clk_in);
    `CHECK("sync error", 1'b1, sync_error_out)
    rd(8'h2c);
    `CHECK("missed", 1'b1, rq != 32'h0)
    miss <= 1'b0;
    late <= 1'b1;
    repeat (120) @(posedge sys_clk_in);
    rd(8'h30);
    `CHECK("overrun", 1'b1, rq != 32'h0)
    late <= 1'b0;
    wr(8'h04, 32'h0);
    repeat (10) @(posedge sys_clk_in);
    `CHECK("error cleared", 1'b0, sync_error_out)
    $display("events done");
    summarize();
  end
endmodule : test_input_sync_parameters
bind input_sync_parameters input_sync_parameters_monitor u_input_sync_parameters_monitor (.sys_clk_in, .reset_in,
  .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
  .avs_waitrequest_out, .avs_response_err_out, .sync_mode_out, .measuring_out);
